// *** hw/refresh_timer_map.vh ***
// Purpose: register offsets, field positions and counts for the refresh timer
// Assumes: 32-bit register port, byte addresses
// Notes: definitions only
`ifndef REFRESH_TIMER_MAP_VH
`define REFRESH_TIMER_MAP_VH

`define RT_ADDR_W 8
`define RT_OFS_CTRL_STATUS 8'h00
`define RT_OFS_COUNTER 8'h04
`define RT_OFS_LIMIT 8'h08
`define RT_OFS_REFRESH_CTRL 8'h0C
`define RT_OFS_WAIT_STATUS 8'h10

`define RT_WRITE_KEY 16'hA55A
`define RT_KEY_LSB 16

`define RT_BIT_MATCH_FLAG 7
`define RT_BIT_MATCH_IRQ_EN 6
`define RT_CKS_MSB 5
`define RT_CKS_LSB 3
`define RT_BURST_MSB 2
`define RT_BURST_LSB 0
`define RT_BIT_REFRESH_EN 0

`define RT_CKS_STOP 3'h0
`define RT_PRESCALE_W 11
`define RT_WAIT_TERMINAL 7'h7F
`define RT_RESET_CTRL 8'h00

`endif

// *** hw/count_clock_divider.v ***
// Purpose: prescaler giving one-cycle count enables for the refresh counter
// Assumes: clk is the bus clock
// Notes: code 000 and the unlisted 001/111 give no tick
`timescale 1ns/1ps
module count_clock_divider (
    input wire clk,         // bus clock
    input wire sys_rst,     // async reset, active high
    input wire [2:0] sel,   // count clock select
    output reg tick         // one-cycle count enable
);
`include "refresh_timer_map.vh"

reg [`RT_PRESCALE_W-1:0] pre_reg;

// a free-running prescaler is cheaper than one per ratio; first tick phase varies
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        pre_reg <= {`RT_PRESCALE_W{1'b0}};
        tick <= 1'b0;
    end else begin
        pre_reg <= pre_reg + 11'h001;
        case (sel)
            3'h2: tick <= (pre_reg[3:0] == 4'hF);
            3'h3: tick <= (pre_reg[5:0] == 6'h3F);
            3'h4: tick <= (pre_reg[7:0] == 8'hFF);
            3'h5: tick <= (pre_reg[9:0] == 10'h3FF);
            3'h6: tick <= (pre_reg == 11'h7FF);
            default: tick <= 1'b0;
        endcase
    end
end

endmodule

// *** hw/sdram_refresh_interval_timer.v ***
// Purpose: refresh interval timer with key-guarded registers and reset wait
// Assumes: single 250 MHz clock used as bus clock and external bus clock
// Notes: sequencer acknowledges each request with a one-cycle done pulse
//
// Operation
// - clock select picks counter divider
// - burst field gives one to eight refreshes
// - 8-bit counter steps on each tick
// - counter wraps after 255
// - match sets flag, clears counter
// - writes need key in upper half, except refresh control at 0x0C
// - guarded reads return zero upper half
// - match with enable posts held request
// - second match does not queue request
// - match interrupt held until flag cleared; here it also drops when the enable bit is written zero
// - flag clear leaves refresh request alone
// - limit is 8 bits, upper zero
// - 7-bit wait counter stops at 127
// - bus access held while waiting
// - wait counter invisible to software
// - flag clears by zero after read one
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module sdram_refresh_interval_timer (
    input wire clk,                    // bus clock, 250 MHz
    input wire sys_rst,                // async reset, active high
    input wire [7:0] reg_addr,         // register byte address
    input wire [31:0] reg_wdata,       // write data
    input wire reg_wr,                 // write strobe
    input wire reg_rd,                 // read strobe
    output reg [31:0] reg_rdata,       // read data, cycle after strobe
    input wire refresh_done,           // sequencer done pulse
    output reg refresh_req,            // refresh request level
    output reg [3:0] refresh_burst,    // refreshes per request
    output wire match_irq,             // match interrupt level
    output wire bus_access_hold        // high while reset wait runs
);
`include "refresh_timer_map.vh"

////////////////////////////////////////////////////////////////////////////////
// register state

reg match_flag_reg;
reg match_irq_enable_reg;
reg [2:0] count_clock_select_reg;
reg [2:0] refresh_burst_count_reg;
reg refresh_enable_reg;
reg [7:0] refresh_interval_counter_reg;
reg [7:0] refresh_interval_limit_reg;
reg flag_seen_one_reg;
reg [6:0] reset_wait_counter_reg;
reg [31:0] rdata_next;
wire tick;
wire match;
wire key_ok;
wire wr_ctrl;
wire wr_cnt;
wire wr_lim;
wire flag_clear;

function [3:0] burst_decode;
    input [2:0] code;
    begin
        case (code)
            3'h0: burst_decode = 4'h1;
            3'h1: burst_decode = 4'h2;
            3'h2: burst_decode = 4'h4;
            3'h3: burst_decode = 4'h6;
            3'h4: burst_decode = 4'h8;
            default: burst_decode = 4'h1; // prohibited codes fall back to one
        endcase
    end
endfunction

function [31:0] guarded_word;
    input [7:0] low;
    begin
        guarded_word = {24'h00_0000, low};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// prescaler

count_clock_divider divider (
    .clk(clk),
    .sys_rst(sys_rst),
    .sel(count_clock_select_reg),
    .tick(tick)
);

////////////////////////////////////////////////////////////////////////////////
// write decode

assign key_ok = (reg_wdata[31:`RT_KEY_LSB] == `RT_WRITE_KEY);
assign wr_ctrl = reg_wr && key_ok && (reg_addr == `RT_OFS_CTRL_STATUS);
assign wr_cnt = reg_wr && key_ok && (reg_addr == `RT_OFS_COUNTER);
assign wr_lim = reg_wr && key_ok && (reg_addr == `RT_OFS_LIMIT);

// zero write counts only after a read that saw the flag set
assign flag_clear = wr_ctrl && !reg_wdata[`RT_BIT_MATCH_FLAG]
                    && flag_seen_one_reg;

assign match = tick && (refresh_interval_counter_reg == refresh_interval_limit_reg);

////////////////////////////////////////////////////////////////////////////////
// control register

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        match_irq_enable_reg <= 1'b0;
        count_clock_select_reg <= `RT_CKS_STOP;
        refresh_burst_count_reg <= 3'h0;
        refresh_enable_reg <= 1'b0;
        refresh_interval_limit_reg <= `RT_RESET_CTRL;
    end else begin
        if (wr_ctrl) begin
            match_irq_enable_reg <= reg_wdata[`RT_BIT_MATCH_IRQ_EN];
            count_clock_select_reg <= reg_wdata[`RT_CKS_MSB:`RT_CKS_LSB];
            refresh_burst_count_reg <= reg_wdata[`RT_BURST_MSB:`RT_BURST_LSB];
        end
        if (wr_lim) begin
            refresh_interval_limit_reg <= reg_wdata[7:0];
        end
        // refresh enable has no key: it stands in for the sdram control register
        if (reg_wr && reg_addr == `RT_OFS_REFRESH_CTRL) begin
            refresh_enable_reg <= reg_wdata[`RT_BIT_REFRESH_EN];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interval counter and match flag

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        refresh_interval_counter_reg <= 8'h00;
    end else if (wr_cnt) begin
        refresh_interval_counter_reg <= reg_wdata[7:0];
    end else if (match) begin
        refresh_interval_counter_reg <= 8'h00;
    end else if (tick) begin
        // natural 8-bit wrap from 255 to 0
        refresh_interval_counter_reg <= refresh_interval_counter_reg + 8'h01;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        match_flag_reg <= 1'b0;
        flag_seen_one_reg <= 1'b0;
    end else begin
        if (match) begin
            match_flag_reg <= 1'b1; // set wins over clear
        end else if (flag_clear) begin
            match_flag_reg <= 1'b0;
        end
        if (reg_rd && reg_addr == `RT_OFS_CTRL_STATUS && match_flag_reg) begin
            flag_seen_one_reg <= 1'b1;
        end else if (wr_ctrl) begin
            flag_seen_one_reg <= 1'b0;
        end
    end
end

assign match_irq = match_flag_reg && match_irq_enable_reg;

////////////////////////////////////////////////////////////////////////////////
// refresh request

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        refresh_req <= 1'b0;
        refresh_burst <= 4'h1;
    end else begin
        if (match && refresh_enable_reg) begin
            // an unserved request is simply kept, never stacked
            refresh_req <= 1'b1;
            refresh_burst <= burst_decode(refresh_burst_count_reg);
        end else if (refresh_done) begin
            refresh_req <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// reset wait counter, no register path

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        reset_wait_counter_reg <= 7'h00;
    end else if (reset_wait_counter_reg != `RT_WAIT_TERMINAL) begin
        reset_wait_counter_reg <= reset_wait_counter_reg + 7'h01;
    end
end

assign bus_access_hold = (reset_wait_counter_reg != `RT_WAIT_TERMINAL);

////////////////////////////////////////////////////////////////////////////////
// read path

always @* begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
        `RT_OFS_CTRL_STATUS: rdata_next = guarded_word({match_flag_reg, match_irq_enable_reg,
                                    count_clock_select_reg, refresh_burst_count_reg});
        `RT_OFS_COUNTER: rdata_next = guarded_word(refresh_interval_counter_reg);
        `RT_OFS_LIMIT: rdata_next = guarded_word(refresh_interval_limit_reg);
        `RT_OFS_REFRESH_CTRL: rdata_next = {31'h0000_0000, refresh_enable_reg};
        // wait counter deliberately absent; unmapped reads give zero
        default: rdata_next = 32'h0000_0000;
    endcase
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
        reg_rdata <= rdata_next;
    end else begin
        reg_rdata <= 32'h0000_0000;
    end
end

endmodule

// *** sim/refresh_sequencer_model.sv ***
// Purpose: behavioural refresh sequencer facing the timer
// Assumes: one clock shared with the timer
// Notes: slow gives four cycles a refresh; hold_off stalls service
`timescale 1ns/1ps
module refresh_sequencer_model (
    input wire clk, // bus clock
    input wire sys_rst, // async reset
    input wire refresh_req, // timer request
    input wire [3:0] refresh_burst, // refreshes asked
    input wire slow, // long refreshes
    input wire hold_off, // stall service
    output reg refresh_done, // one-cycle ack
    output reg [7:0] served // refreshes issued
);
    reg [7:0] left_reg;
    ////////////////////////////////////////
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refresh_done <= 1'b0;
            served <= 8'h00;
            left_reg <= 8'h00;
        end else begin
            refresh_done <= 1'b0;
            if (!refresh_req || refresh_done || hold_off) begin
                left_reg <= 8'h00;
            end else if (left_reg == 8'h00) begin
                left_reg <= slow ? {2'b00, refresh_burst, 2'b00} : {4'h0, refresh_burst};
            end else if (left_reg == 8'h01) begin
                // ack only once the whole burst is out
                refresh_done <= 1'b1;
                served <= served + {4'h0, refresh_burst};
            end else begin
                left_reg <= left_reg - 8'h01;
            end
        end
    end
endmodule

// *** sim/refresh_timer_checker.sv ***
// Purpose: port checks for the refresh interval timer
// Assumes: single clock, sys_rst async active high
// Notes: bound to every timer instance
`timescale 1ns/1ps
module refresh_timer_checker (
    input wire clk, // bus clock
    input wire sys_rst, // async reset
    input wire [7:0] reg_addr, // address
    input wire reg_rd, // read strobe
    input wire reg_wr, // write strobe
    input wire [31:0] reg_rdata, // read data
    input wire refresh_done, // ack
    input wire refresh_req, // request
    input wire [3:0] refresh_burst, // burst
    input wire match_irq, // interrupt
    input wire bus_access_hold // wait hold
);
    reg [7:0] wait_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // shadow of the reset wait count
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) wait_reg <= 8'h00;
        else if (wait_reg != 8'h7F) wait_reg <= wait_reg + 8'h01;
    end
    AST_RDATA_UPPER: assert property (
        reg_rdata[31:16] == 16'h0000) else $error("upper read half set");
    AST_LIMIT_UPPER: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h08 |-> reg_rdata[31:8] == 24'h00_0000)
        else $error("limit upper bits set");
    AST_REQ_HOLD: assert property (
        refresh_req && !refresh_done |=> refresh_req) else $error("request dropped");
    AST_REQ_DROP: assert property (
        $fell(refresh_req) |-> $past(refresh_done)) else $error("request fell early");
    AST_BURST: assert property (
        refresh_req |-> refresh_burst inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
        else $error("bad burst size");
    AST_WAIT_COUNT: assert property (
        bus_access_hold == (wait_reg != 8'h7F)) else $error("wait length wrong");
    AST_HOLD_STAYS: assert property (
        !bus_access_hold |=> !bus_access_hold) else $error("hold came back");
    AST_IRQ_HOLD: assert property (
        match_irq && !(reg_wr && reg_addr == 8'h00) |=> match_irq)
        else $error("irq dropped");
    cover property ($rose(refresh_req));
    cover property ($fell(match_irq));
    cover property ($fell(bus_access_hold));
endmodule
bind sdram_refresh_interval_timer refresh_timer_checker u_chk (.*);

// *** sim/sdram_refresh_interval_timer_tb_top.sv ***
// Purpose: directed bench for the refresh interval timer
// Assumes: 250 MHz clock, sequencer model on the refresh link
// Notes: tick phase is free, so rate checks allow one tick
`timescale 1ns/1ps
module sdram_refresh_interval_timer_tb_top;
    reg clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, hold_off = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0000_0000;
    wire [31:0] reg_rdata;
    wire refresh_done, refresh_req, match_irq, bus_access_hold;
    wire [3:0] refresh_burst;
    wire [7:0] served;
    integer fail_count = 0, compares = 0, n, b, s0;
    always #2 clk = ~clk;
    sdram_refresh_interval_timer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .refresh_done(refresh_done), .refresh_req(refresh_req), .refresh_burst(refresh_burst),
        .match_irq(match_irq), .bus_access_hold(bus_access_hold));
    refresh_sequencer_model seq (.clk(clk), .sys_rst(sys_rst), .refresh_req(refresh_req),
        .refresh_burst(refresh_burst), .slow(slow), .hold_off(hold_off),
        .refresh_done(refresh_done), .served(served));
    ////////////////////////////////////////
    task end_sim;
        begin
            $display("compares %0d mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [63:0] what, input [31:0] exp, input [31:0] got, input [31:0] tol);
        begin
            compares = compares + 1;
            if (^got === 1'bx || got - exp + tol > 2 * tol) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp, input [31:0] tol);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk("rdata", exp, reg_rdata, tol);
        end
    endtask
    task wait_req(input lvl);
        begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n = n + 1;
            end while (refresh_req !== lvl && n < 300);
            if (n == 300) begin
                chk("timeout", 0, 1, 0);
                end_sim;
            end
        end
    endtask
    task rate(input [7:0] ctrl, input [7:0] start, input integer cyc, input [7:0] exp);
        begin
            wr(8'h04, {16'hA55A, 8'h00, start});
            wr(8'h00, {16'hA55A, 8'h00, ctrl});
            repeat (cyc) @(posedge clk);
            wr(8'h00, 32'hA55A_0000);
            rd(8'h04, exp, 1);
            $display("done rate");
        end
    endtask
    task t_key;
        begin
            wr(8'h08, 32'hFFFF_00AB);
            rd(8'h08, 32'h0000_0000, 0);
            wr(8'h08, 32'hA55A_FF3C);
            rd(8'h08, 32'h0000_003C, 0);
            wr(8'h04, 32'hA55A_0077);
            repeat (40) @(posedge clk);
            rd(8'h04, 32'h0000_0077, 0);
            rd(8'h10, 32'h0000_0000, 0);
            $display("done key");
        end
    endtask
    task t_refresh;
        begin
            wr(8'h08, 32'hA55A_0002);
            wr(8'h0C, 32'h0000_0001);
            for (b = 0; b < 6; b = b + 1) begin
                slow <= b[0];
                wr(8'h00, 32'hA55A_0050 | b);
                wait_req(1'b1);
                chk("burst", (b == 0 || b == 5) ? 1 : 2 * b, refresh_burst, 0);
                chk("irq", 1, match_irq, 0);
                rd(8'h00, 32'h0000_00D0 | b, 0);
                wr(8'h00, 32'hA55A_0000);
                wait_req(1'b0);
            end
            hold_off <= 1'b1;
            wr(8'h00, 32'hA55A_0050);
            wait_req(1'b1);
            wr(8'h00, 32'hA55A_0040);
            #1 chk("irq", 1, match_irq, 0);
            rd(8'h00, 32'h0000_00C0, 0);
            wr(8'h00, 32'hA55A_0040);
            #1 chk("irq", 0, match_irq, 0);
            chk("req", 1, refresh_req, 0);
            wr(8'h00, 32'hA55A_0010);
            repeat (120) @(posedge clk);
            wr(8'h00, 32'hA55A_0000);
            s0 = served;
            hold_off <= 1'b0;
            wait_req(1'b0);
            repeat (20) @(posedge clk);
            #1 chk("req", 0, refresh_req, 0);
            chk("served", s0 + 1, served, 0);
            $display("done refresh");
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        n = 0;
        while (bus_access_hold === 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        chk("wait", 127, n, 0);
        $display("done wait");
        t_key;
        rate(8'h10, 8'h00, 640, 40);
        rate(8'h18, 8'h00, 640, 10);
        rate(8'h20, 8'h00, 640, 2);
        rate(8'h28, 8'h00, 2100, 2);
        rate(8'h30, 8'h00, 4200, 2);
        rate(8'h10, 8'hFE, 64, 2);
        t_refresh;
        end_sim;
    end
endmodule
